// >>> caf_acceptance_filter.sv
// Acceptance filter for the CAN receive path with AXI4-Lite registers.

module caf_acceptance_filter (
    input  wire logic              aclk,          // Controller clock.
    input  wire logic              aresetn,       // Synchronous reset.
    input  wire logic [11:0]       s_axil_awaddr, // Write address.
    input  wire logic              s_axil_awvalid,// Write address valid.
    output logic                   s_axil_awready,// Write address ready.
    input  wire logic [31:0]       s_axil_wdata,  // Write data.
    input  wire logic [3:0]        s_axil_wstrb,  // Byte enables.
    input  wire logic              s_axil_wvalid, // Write data valid.
    output logic                   s_axil_wready, // Write data ready.
    output logic [1:0]             s_axil_bresp,  // Write response.
    output logic                   s_axil_bvalid, // Response valid.
    input  wire logic              s_axil_bready, // Response ready.
    input  wire logic [11:0]       s_axil_araddr, // Read address.
    input  wire logic              s_axil_arvalid,// Read address valid.
    output logic                   s_axil_arready,// Read address ready.
    output logic [31:0]            s_axil_rdata,  // Read data.
    output logic [1:0]             s_axil_rresp,  // Read response.
    output logic                   s_axil_rvalid, // Read data valid.
    input  wire logic              s_axil_rready, // Read data ready.
    input  wire caf_pkg::caf_frame_t  frame,      // Received identifier.
    output caf_pkg::caf_result_t   result         // Filter outcome.
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [31:0]             bank_q [caf_pkg::NW];
    logic [31:0]             bank_d [caf_pkg::NW];
    logic [caf_pkg::NB-1:0]  mode_q, mode_d, scale_q, scale_d;
    logic [caf_pkg::NB-1:0]  fifo_q, fifo_d, act_q, act_d;
    logic                    aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [11:0]             awaddr_q, awaddr_d;
    logic [31:0]             wdata_q, wdata_d;
    logic [3:0]              wstrb_q, wstrb_d;
    logic                    awready_q, awready_d, wready_q, wready_d;
    logic                    bvalid_q, bvalid_d, arready_q, arready_d;
    logic                    rvalid_q, rvalid_d;
    logic [1:0]              bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]             rdata_q, rdata_d;
    caf_pkg::caf_result_t    res_q, res_d;

    // Per-bank match results and running filter numbers.
    logic [3:0]              hit [caf_pkg::NB];
    logic [1:0]              cls [caf_pkg::NB];
    logic [caf_pkg::IW-1:0]  bs0 [caf_pkg::NB+1];
    logic [caf_pkg::IW-1:0]  bs1 [caf_pkg::NB+1];
    logic [31:0]             key32;
    logic [15:0]             key16;

    // Merges a write into a word under its byte enables.
    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // Compare keys
    // ------------------------------------------------------------
    // Frame identifier laid out as in a 32-bit and a 16-bit entry.
    assign key32 = {frame.standard_id_bits, frame.extended_id_bits,
                    frame.frame_format_bit, frame.frame_type_bit, 1'b0};
    assign key16 = {frame.standard_id_bits, frame.frame_type_bit,
                    frame.frame_format_bit,
                    frame.extended_id_bits[17:15]};

    assign bs0[0] = '0;
    assign bs1[0] = '0;

    // ------------------------------------------------------------
    // Bank matching and numbering
    // ------------------------------------------------------------
    // Each bank has two words and either scale; up to four slots hit.
    for (genvar b = 0; b < caf_pkg::NB; b++) begin : g_bank
        logic [31:0]            w0, w1;
        logic [3:0]             raw;
        logic [caf_pkg::IW-1:0] cnt;
        assign w0 = bank_q[2*b];
        assign w1 = bank_q[2*b+1];

        // Slot hits for the four mode and scale combinations.
        always_comb begin
            raw = 4'h0;
            if (scale_q[b] && !mode_q[b]) begin
                raw[0] = ((key32 ^ w0) & w1 & caf_pkg::W32_CMP) == '0;
            end else if (scale_q[b]) begin
                raw[0] = ((key32 ^ w0) & caf_pkg::W32_CMP) == '0;
                raw[1] = ((key32 ^ w1) & caf_pkg::W32_CMP) == '0;
            end else if (!mode_q[b]) begin
                raw[0] = ((key16 ^ w0[15:0]) & w0[31:16]) == '0;
                raw[1] = ((key16 ^ w1[15:0]) & w1[31:16]) == '0;
            end else begin
                raw[0] = key16 == w0[15:0];
                raw[1] = key16 == w0[31:16];
                raw[2] = key16 == w1[15:0];
                raw[3] = key16 == w1[31:16];
            end
        end

        // Only an active bank may hit, but every bank takes numbers.
        assign hit[b] = act_q[b] ? raw : 4'h0;
        assign cls[b] = {~scale_q[b], ~mode_q[b]};
        assign cnt = scale_q[b] ? (mode_q[b] ? 8'h02 : 8'h01)
                                : (mode_q[b] ? 8'h04 : 8'h02);
        assign bs0[b+1] = bs0[b] + (fifo_q[b] ? 8'h00 : cnt);
        assign bs1[b+1] = bs1[b] + (fifo_q[b] ? cnt : 8'h00);
    end

    // ------------------------------------------------------------
    // Winner selection and result
    // ------------------------------------------------------------
    // Lowest class wins; ties go to the lower bank and slot.
    always_comb begin
        logic [2:0] best;
        best = 3'h4;
        res_d = res_q;
        res_d.valid = 1'b0;
        if (frame.valid) begin
            res_d.valid = 1'b1;
            res_d.pass = 1'b0;
            for (int b = 0; b < caf_pkg::NB; b++) begin
                for (int s = 0; s < 4; s++) begin
                    if (hit[b][s] && {1'b0, cls[b]} < best) begin
                        best = {1'b0, cls[b]};
                        res_d.pass = 1'b1;
                        res_d.fifo = fifo_q[b];
                        res_d.bank = 5'(b);
                        res_d.filter_index_field =
                            (fifo_q[b] ? bs1[b] : bs0[b]) + 8'(s);
                    end
                end
            end
        end
    end

    // Result register feeding the receive FIFOs.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Next state of the bus handshakes and configuration storage.
    always_comb begin
        logic [11:0] a;
        a = awaddr_q;
        bank_d = bank_q;
        mode_d = mode_q;
        scale_d = scale_q;
        fifo_d = fifo_q;
        act_d = act_q;
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axil_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            awaddr_d = s_axil_awaddr;
        end
        if (s_axil_wvalid && wready_q) begin
            w_got_d = 1'b1;
            wdata_d = s_axil_wdata;
            wstrb_d = s_axil_wstrb;
        end
        if (bvalid_q && s_axil_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_got_q && w_got_q && !bvalid_q) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = caf_pkg::RESP_OK;
            if (a < caf_pkg::A_BANK_END) begin
                bank_d[a[7:2]] = merge(bank_q[a[7:2]], wdata_q, wstrb_q);
            end else if (a == caf_pkg::A_MODE) begin
                mode_d = (caf_pkg::NB)'(merge(32'(mode_q), wdata_q, wstrb_q));
            end else if (a == caf_pkg::A_SCALE) begin
                scale_d = (caf_pkg::NB)'(merge(32'(scale_q), wdata_q,
                                               wstrb_q));
            end else if (a == caf_pkg::A_FIFO) begin
                fifo_d = (caf_pkg::NB)'(merge(32'(fifo_q), wdata_q, wstrb_q));
            end else if (a == caf_pkg::A_ACT) begin
                act_d = (caf_pkg::NB)'(merge(32'(act_q), wdata_q, wstrb_q));
            end else if (a != caf_pkg::A_STAT) begin
                bresp_d = caf_pkg::RESP_ER;
            end
        end
        if (rvalid_q && s_axil_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axil_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = caf_pkg::RESP_OK;
            rdata_d = 32'h0000_0000;
            unique case (s_axil_araddr)
                caf_pkg::A_MODE:  rdata_d = 32'(mode_q);
                caf_pkg::A_SCALE: rdata_d = 32'(scale_q);
                caf_pkg::A_FIFO:  rdata_d = 32'(fifo_q);
                caf_pkg::A_ACT:   rdata_d = 32'(act_q);
                caf_pkg::A_STAT:  rdata_d = 32'(res_q[14:0]);
                default: begin
                    if (s_axil_araddr < caf_pkg::A_BANK_END) begin
                        rdata_d = bank_q[s_axil_araddr[7:2]];
                    end else begin
                        rresp_d = caf_pkg::RESP_ER;
                    end
                end
            endcase
        end
        awready_d = !aw_got_d && !bvalid_d;
        wready_d = !w_got_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // Registers of the bus slave and the configuration.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < caf_pkg::NW; i++) begin
                bank_q[i] <= caf_pkg::RST_WORD;
            end
            mode_q <= caf_pkg::RST_CFG;
            scale_q <= caf_pkg::RST_CFG;
            fifo_q <= caf_pkg::RST_CFG;
            act_q <= caf_pkg::RST_CFG;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= 2'h0;
        end else begin
            bank_q <= bank_d;
            mode_q <= mode_d;
            scale_q <= scale_d;
            fifo_q <= fifo_d;
            act_q <= act_d;
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Outputs straight from their flip-flops.
    assign s_axil_awready = awready_q;
    assign s_axil_wready = wready_q;
    assign s_axil_bvalid = bvalid_q;
    assign s_axil_bresp = bresp_q;
    assign s_axil_arready = arready_q;
    assign s_axil_rvalid = rvalid_q;
    assign s_axil_rdata = rdata_q;
    assign s_axil_rresp = rresp_q;
    assign result = res_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_frame_result: assert property (@(posedge aclk)
        disable iff (!aresetn) frame.valid |=> result.valid)
        else $error("Frame gave no result.");
    chk_no_stray: assert property (@(posedge aclk)
        disable iff (!aresetn) !frame.valid |=> !result.valid)
        else $error("Result without a frame.");
    chk_active_only: assert property (@(posedge aclk)
        disable iff (!aresetn)
        result.valid && result.pass |-> act_q[result.bank])
        else $error("Inactive bank accepted a frame.");
    chk_fifo_route: assert property (@(posedge aclk)
        disable iff (!aresetn) result.valid && result.pass
        |-> result.fifo == fifo_q[result.bank])
        else $error("Frame routed to wrong FIFO.");
    chk_index_first: assert property (@(posedge aclk)
        disable iff (!aresetn) result.valid && result.pass
        && result.bank == 5'h00 |-> result.filter_index_field < 8'h04)
        else $error("Bank 0 index out of range.");
    chk_drop_miss: assert property (@(posedge aclk)
        disable iff (!aresetn) frame.valid && act_q == '0 |=> !result.pass)
        else $error("Frame passed with no active bank.");
    chk_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
        else $error("Write response dropped early.");
    chk_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid
        && $stable(s_axil_rdata))
        else $error("Read data changed while stalled.");

endmodule : caf_acceptance_filter

// >>> caf_acceptance_filter_tb.sv
// Self-checking testbench for the CAN acceptance filter.
module caf_acceptance_filter_tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [10:0] sid;
        logic [17:0] eid;
        logic        fmt;
        logic        pass;
        logic        fifo;
        logic [4:0]  bank;
        logic [7:0]  idx;
    } caf_row_t;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [11:0] s_axil_awaddr = 12'h000, s_axil_araddr = 12'h000;
    logic [31:0] s_axil_wdata = 32'h0000_0000, s_axil_rdata;
    logic [3:0]  s_axil_wstrb = 4'h0;
    logic        s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0;
    logic        s_axil_bready = 1'b0, s_axil_arvalid = 1'b0;
    logic        s_axil_rready = 1'b0;
    logic        s_axil_awready, s_axil_wready, s_axil_bvalid;
    logic        s_axil_arready, s_axil_rvalid;
    logic [1:0]  s_axil_bresp, s_axil_rresp, r;
    logic [31:0] d;
    caf_pkg::caf_frame_t  frame;
    caf_pkg::caf_result_t result;
    caf_row_t    q[$];
    int          failures = 0, check_count = 0, i;

    // Clock of 40 ns period.
    always #20 aclk = ~aclk;

    caf_frame_src i_src (.aclk(aclk), .frame(frame));

    caf_acceptance_filter i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axil_awaddr(s_axil_awaddr), .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready), .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb), .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready), .frame(frame), .result(result));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            failures++;
        end
    endtask : check

    // Offers address and data together and waits for the response.
    task automatic axi_write(input logic [11:0] a, input logic [31:0] v,
                             input logic [3:0] s, output logic [1:0] rs);
        logic aw, w;
        int   n;
        rs = 2'h3;
        aw = 1'b1;
        w  = 1'b1;
        @(posedge aclk);
        s_axil_awaddr  <= a;
        s_axil_wdata   <= v;
        s_axil_wstrb   <= s;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid  <= 1'b1;
        s_axil_bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (aw && s_axil_awready) begin
                aw = 1'b0;
                s_axil_awvalid <= 1'b0;
            end
            if (w && s_axil_wready) begin
                w = 1'b0;
                s_axil_wvalid <= 1'b0;
            end
            if (s_axil_bvalid === 1'b1) begin
                rs = s_axil_bresp;
                s_axil_bready <= 1'b0;
                break;
            end
        end
        if (n == 50) failures++;
    endtask : axi_write

    // Offers a read address and waits for the data.
    task automatic axi_read(input logic [11:0] a, output logic [31:0] v,
                            output logic [1:0] rs);
        logic ar;
        int   n;
        rs = 2'h3;
        v  = 32'hDEAD_BEEF;
        ar = 1'b1;
        @(posedge aclk);
        s_axil_araddr  <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (ar && s_axil_arready) begin
                ar = 1'b0;
                s_axil_arvalid <= 1'b0;
            end
            if (s_axil_rvalid === 1'b1) begin
                v  = s_axil_rdata;
                rs = s_axil_rresp;
                s_axil_rready <= 1'b0;
                break;
            end
        end
        if (n == 50) failures++;
    endtask : axi_read

    task automatic cfg(input logic [11:0] a, input logic [31:0] v);
        logic [1:0] rs;
        axi_write(a, v, 4'hF, rs);
        check(32'(rs), 32'(caf_pkg::RESP_OK));
    endtask : cfg

    task automatic row(input logic [10:0] s, input logic [17:0] e,
                       input logic f, p, fo, input logic [4:0] b,
                       input logic [7:0] x);
        q.push_back({s, e, f, p, fo, b, x});
    endtask : row

    task automatic check_row(input caf_row_t w);
        check(32'(result.valid), 32'h1);
        check(32'(result.pass), 32'(w.pass));
        if (w.pass) begin
            check(32'(result.fifo), 32'(w.fifo));
            check(32'(result.bank), 32'(w.bank));
            check(32'(result.filter_index_field), 32'(w.idx));
        end
    endtask : check_row

    // Frames go back to back; each result is checked one edge later.
    task automatic run_frames(input int lo, input int hi);
        for (int k = lo; k <= hi + 1; k++) begin
            if (k <= hi) i_src.send(1'b1, q[k].sid, q[k].eid, q[k].fmt);
            else i_src.send(1'b0, 11'h000, 18'h00000, 1'b0);
            #1;
            if (k > lo) check_row(q[k-1]);
        end
        i_src.send(1'b0, 11'h000, 18'h00000, 1'b0);
        #1;
        check(32'(result.valid), 32'h0);
    endtask : run_frames

    task automatic summarize;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    // Watchdog that cuts a hang short.
    initial begin
        #400000;
        failures++;
        summarize();
    end

    // Main sequence: reset, register checks, bank setup, frames.
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 4; i++) begin
            axi_read(caf_pkg::A_MODE + 12'(4 * i), d, r);
            check(d, {4'h0, caf_pkg::RST_CFG});
        end
        axi_read(12'h00C, d, r);
        check(d, caf_pkg::RST_WORD);
        axi_read(caf_pkg::A_BANK_END, d, r);
        check(32'(r), 32'(caf_pkg::RESP_ER));
        check(d, 32'h0000_0000);
        axi_write(12'h200, 32'hFFFF_FFFF, 4'hF, r);
        check(32'(r), 32'(caf_pkg::RESP_ER));
        // Byte strobes: only the second byte of bank 4 word 0 lands.
        axi_write(12'h020, 32'hFFFF_FFFF, 4'h2, r);
        axi_read(12'h020, d, r);
        check(d, 32'h0000_FF00);
        cfg(12'h000, 32'h2460_0000);
        cfg(12'h004, 32'hFE00_0004);
        cfg(12'h008, 32'h4000_0000);
        cfg(12'h00C, 32'h4020_0000);
        cfg(12'h010, 32'hFFF8_8000);
        cfg(12'h014, 32'hFFF8_8200);
        cfg(12'h018, 32'hFFF8_6000);
        cfg(12'h01C, 32'hFFF8_6000);
        cfg(12'h028, 32'hA020_A000);
        cfg(12'h02C, 32'hA060_A040);
        cfg(12'h030, 32'h2400_C000);
        cfg(12'h038, 32'h4000_0000);
        cfg(12'h03C, 32'hFE00_0000);
        cfg(caf_pkg::A_MODE, 32'h0000_0072);
        cfg(caf_pkg::A_SCALE, 32'h0000_0083);
        cfg(caf_pkg::A_FIFO, 32'h0000_00B4);
        cfg(caf_pkg::A_ACT, 32'h0000_00E7);
        axi_read(caf_pkg::A_MODE, d, r);
        check(d, 32'h0000_0072);
        row(11'h123, 18'h00000, 1'b0, 1'b1, 1'b0, 5'h00, 8'h00);
        row(11'h12C, 18'h00000, 1'b0, 1'b1, 1'b0, 5'h00, 8'h00);
        row(11'h125, 18'h00000, 1'b1, 1'b0, 1'b0, 5'h00, 8'h00);
        row(11'h201, 18'h00000, 1'b0, 1'b1, 1'b0, 5'h01, 8'h02);
        row(11'h200, 18'h00000, 1'b0, 1'b1, 1'b0, 5'h01, 8'h01);
        row(11'h20F, 18'h00000, 1'b0, 1'b1, 1'b1, 5'h07, 8'h0A);
        row(11'h410, 18'h00000, 1'b0, 1'b1, 1'b1, 5'h02, 8'h01);
        row(11'h400, 18'h08000, 1'b0, 1'b1, 1'b1, 5'h02, 8'h00);
        row(11'h300, 18'h00000, 1'b0, 1'b0, 1'b0, 5'h00, 8'h00);
        row(11'h600, 18'h00000, 1'b0, 1'b1, 1'b0, 5'h06, 8'h05);
        row(11'h601, 18'h00000, 1'b0, 1'b0, 1'b0, 5'h00, 8'h00);
        row(11'h120, 18'h00000, 1'b0, 1'b1, 1'b0, 5'h00, 8'h00);
        for (i = 0; i < 4; i++) begin
            row(11'h500 + 11'(i), 18'h0, 1'b0, 1'b1, 1'b1, 5'h05,
                8'(6 + i));
        end
        run_frames(0, 15);
        axi_read(caf_pkg::A_STAT, d, r);
        check(d, 32'h0000_6509);
        axi_write(caf_pkg::A_STAT, 32'h0000_0000, 4'hF, r);
        check(32'(r), 32'(caf_pkg::RESP_OK));
        axi_read(caf_pkg::A_STAT, d, r);
        check(d, 32'h0000_6509);
        // Bank 0 switched off: it drops its frames, numbering stays.
        cfg(caf_pkg::A_ACT, 32'h0000_00E6);
        row(11'h123, 18'h00000, 1'b0, 1'b0, 1'b0, 5'h00, 8'h00);
        row(11'h201, 18'h00000, 1'b0, 1'b1, 1'b0, 5'h01, 8'h02);
        run_frames(16, 17);
        // No bank active at all: every frame is dropped.
        cfg(caf_pkg::A_ACT, 32'h0000_0000);
        row(11'h201, 18'h00000, 1'b0, 1'b0, 1'b0, 5'h00, 8'h00);
        run_frames(18, 18);
        summarize();
    end
endmodule : caf_acceptance_filter_tb

// >>> caf_frame_src.sv
// Behavioural model of the protocol engine that hands identifiers on.
module caf_frame_src (
    input  wire logic           aclk,  // Controller clock.
    output caf_pkg::caf_frame_t frame  // Identifier towards the filter.
);
    timeunit 1ns;
    timeprecision 1ns;

    caf_pkg::caf_frame_t last_q = '0;  // Last identifier sent.

    // The link starts idle with every field low.
    initial frame = '0;

    // Sends one identifier for one cycle, or idles when v is low.
    task automatic send(input logic v, input logic [10:0] s,
                        input logic [17:0] e, input logic f);
        caf_pkg::caf_frame_t nxt;
        @(posedge aclk);
        nxt = {1'b1, s, e, f, 1'b0};
        if (v) begin
            frame  <= nxt;
            last_q = nxt;
        end else begin
            // Stale fields are inverted so that nothing may trust them.
            frame <= {1'b0, ~last_q[30:0]};
        end
    endtask : send
endmodule : caf_frame_src

// >>> caf_pkg.sv
// Constants, types and register map of the CAN acceptance filter.
package caf_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NB = 28;          // Filter banks.
    localparam int NW = 2 * NB;      // Bank data words.
    localparam int AW = 12;          // Register address width.
    localparam int IW = 8;           // Filter index width.

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [AW-1:0] A_BANK_END = 12'h0E0; // Bank words below.
    localparam logic [AW-1:0] A_MODE     = 12'h100; // 1 = list mode.
    localparam logic [AW-1:0] A_SCALE    = 12'h104; // 1 = 32-bit scale.
    localparam logic [AW-1:0] A_FIFO     = 12'h108; // 1 = receive FIFO 1.
    localparam logic [AW-1:0] A_ACT      = 12'h10C; // 1 = bank active.
    localparam logic [AW-1:0] A_STAT     = 12'h110; // Last result.
    localparam logic [31:0]   RST_WORD   = 32'h0000_0000;
    localparam logic [NB-1:0] RST_CFG    = 28'h000_0000;

    // ------------------------------------------------------------
    // Field layout of the compare keys
    // ------------------------------------------------------------
    localparam logic [31:0] W32_CMP = 32'hFFFF_FFFE; // Bit 0 unused.
    localparam logic [1:0]  RESP_OK = 2'h0;
    localparam logic [1:0]  RESP_ER = 2'h2;

    // Identifier of one received frame from the protocol engine.
    typedef struct packed {
        logic        valid;
        logic [10:0] standard_id_bits;
        logic [17:0] extended_id_bits;
        logic        frame_format_bit;
        logic        frame_type_bit;
    } caf_frame_t;

    // Filtering outcome, forming the rx_fifo_property_word index.
    typedef struct packed {
        logic          valid;
        logic          pass;
        logic          fifo;
        logic [4:0]    bank;
        logic [IW-1:0] filter_index_field;
    } caf_result_t;

endpackage : caf_pkg
